// File: hdl/fwp_pkg.sv
// Functional notes
// - Programming only clears bits (stored AND new), one 256-byte page at a time.
// - Erase sets bits to one and comes only per 4KB subsector, 64KB sector or whole array.
// - The array holds 8,388,608 bytes addressed from zero, last byte 007F FFFFh.
// - 128 sectors of 64KB and 2048 subsectors of 4KB; sector n holds subsectors 16n to 16n+15.
// - A 64-byte one-time-programmable area sits outside the array and no array address reaches it.
// - Program, erase and register writes run only if the clock count of the frame is a whole number of bytes.
// - Modifying commands need the write-enable latch, which the write-enable command sets.
// - No stored data changes while the power-on supervisor reports the supply out of range.
// - A sector whose write-lock bit is one refuses program and erase.
// - A sector whose lock-down bit is one keeps its lock state until reset.
// - The sector lock write changes a sector only while its lock-down bit is clear.
// - Top/bottom zero: protect codes 1 to 7 guard the highest 1..64 sectors, code 0 none, codes 8 up all.
// - Top/bottom one: the same decode counts from sector 0 upward.
// - With write-protect low outside quad mode the protect setting cannot be written.
package fwp_pkg;
  localparam int ADDR_W     = 24;
  localparam int ARR_W      = 23;
  localparam int SECT_N     = 128;
  localparam int SECT_W     = 7;
  localparam int SECT_LSB   = 16;
  localparam int SUB_N      = 2048;
  localparam int OTP_W      = 6;
  localparam int BITCNT_W   = 3;
  localparam logic [ARR_W-1:0] ARRAY_LAST = 23'h7fffff;
  localparam logic [ARR_W-1:0] PAGE_MASK  = 23'h0000ff;
  localparam logic [ARR_W-1:0] SUB_MASK   = 23'h000fff;
  localparam logic [ARR_W-1:0] SECT_MASK  = 23'h00ffff;
  localparam logic [7:0]       ERASED     = 8'hff;
  // apb map, byte addresses
  localparam logic [11:0] REG_STATUS    = 12'h000;
  localparam logic [11:0] REG_CONFIG    = 12'h004;
  localparam logic [11:0] REG_LOCK_SEL  = 12'h008;
  localparam logic [11:0] REG_LOCK_STAT = 12'h00c;
  localparam logic [11:0] REG_REFUSED   = 12'h010;
  // status and config fields
  localparam int ST_WEL    = 0;
  localparam int ST_BP_LSB = 1;
  localparam int ST_TB     = 5;
  localparam int ST_WPLOCK = 6;
  localparam int ST_SUPPLY = 7;
  localparam int CFG_QUAD  = 0;
  // lock byte fields, also the sector lock write data layout
  localparam int LK_WRITE  = 0;
  localparam int LK_DOWN   = 1;
  // status write data layout
  localparam int WS_BP_LSB = 0;
  localparam int WS_TB     = 4;
  localparam logic [3:0] BP_RST = 4'h0;
  localparam logic       TB_RST = 1'b0;
  // pin order {supply_ok, wr_prot_n, ser_sel_n, ser_clk}
  localparam int PIN_N = 4;
  localparam int PIN_CLK = 0;
  localparam int PIN_SEL = 1;
  localparam int PIN_WP  = 2;
  localparam int PIN_SUP = 3;
  localparam logic [PIN_N-1:0] PIN_IDLE = 4'h6;

  typedef enum logic [3:0] {
    OP_WREN          = 4'h0,
    OP_WRDI          = 4'h1,
    OP_PROG          = 4'h2,
    OP_ERASE_SUB     = 4'h3,
    OP_ERASE_SECT    = 4'h4,
    OP_ERASE_BULK    = 4'h5,
    OP_WR_STATUS     = 4'h6,
    OP_SECTOR_LOCK_WRITE_CMD = 4'h7,
    OP_PROG_OTP      = 4'h8
  } fwp_op_t;

  typedef enum logic [0:0] {
    FR_IDLE = 1'b0,
    FR_SEL  = 1'b1
  } fwp_frame_t;

  typedef struct packed {
    fwp_op_t           op;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } fwp_cmd_t;

  typedef struct packed {
    logic [ARR_W-1:0] first;
    logic [ARR_W-1:0] last;
    logic             otp;
  } fwp_region_t;
endpackage

// File: hdl/fwp_array_protect.sv
`timescale 1ns/1ps
`default_nettype none
module fwp_array_protect #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // pins, asynchronous to pclk
  input  wire logic                 ser_clk,
  input  wire logic                 ser_sel_n,
  input  wire logic                 wr_prot_n,
  input  wire logic                 supply_ok,
  // decoded command from the command decoder
  input  wire logic                 cmd_valid,
  input  wire fwp_pkg::fwp_cmd_t    cmd,
  input  wire logic [7:0]           cur_byte,
  // decision
  output logic                      exec_q,
  output logic                      refused_q,
  output fwp_pkg::fwp_op_t          exec_op_q,
  output fwp_pkg::fwp_region_t      region_q,
  output logic [7:0]                wr_byte_q
);
  logic [fwp_pkg::PIN_N-1:0]    meta_q;
  logic [fwp_pkg::PIN_N-1:0]    pin_q;
  logic                         clk_prev_q;
  fwp_pkg::fwp_frame_t          frame_q;
  logic [fwp_pkg::BITCNT_W-1:0] bit_cnt_q;
  logic                         pend_q;
  fwp_pkg::fwp_cmd_t            cmd_q;
  logic                         wel_q;
  logic [3:0]                   bp_q;
  logic                         tb_q;
  logic                         quad_q;
  logic [fwp_pkg::SECT_W-1:0]   lock_sel_q;
  logic [fwp_pkg::SECT_N-1:0]   wlock_q;
  logic [fwp_pkg::SECT_N-1:0]   ldown_q;
  logic [CNT_W-1:0]             refused_cnt_q;
  logic                         clk_rise;
  logic                         frame_end;
  logic                         wp_locked;
  logic                         supply_s;
  logic                         ok;
  logic                         modifying;
  logic [fwp_pkg::SECT_W-1:0]   sect;
  logic [fwp_pkg::ARR_W-1:0]    addr;
  logic [fwp_pkg::ARR_W-1:0]    mask;
  logic                         decide;
  logic                         apb_wr;
  logic                         apb_setup;

  // true when the block-protect code covers sector s
  function automatic logic bp_covers(input logic [3:0] bp, input logic tb,
                                     input logic [fwp_pkg::SECT_W-1:0] s);
    logic [fwp_pkg::SECT_W:0] n;
    n = '0;
    if (bp[3])
    begin
      bp_covers = 1'b1;
    end
    else if (bp == fwp_pkg::BP_RST)
    begin
      bp_covers = 1'b0;
    end
    else
    begin
      n = (fwp_pkg::SECT_W+1)'(1) << (bp[2:0] - 3'h1);
      if (tb)
        bp_covers = {1'b0, s} < n;
      else
        bp_covers = {1'b0, s} >= (fwp_pkg::SECT_W+1)'(fwp_pkg::SECT_N) - n;
    end
  endfunction

  // two flip-flops on every pin before anything reads it
  genvar gi;
  generate
    for (gi = 0; gi < fwp_pkg::PIN_N; gi++)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta_q[gi] <= fwp_pkg::PIN_IDLE[gi];
          pin_q[gi]  <= fwp_pkg::PIN_IDLE[gi];
        end
        else
        begin
          meta_q[gi] <= (gi == fwp_pkg::PIN_CLK) ? ser_clk :
                        (gi == fwp_pkg::PIN_SEL) ? ser_sel_n :
                        (gi == fwp_pkg::PIN_WP)  ? wr_prot_n : supply_ok;
          pin_q[gi]  <= meta_q[gi];
        end
      end
    end
  endgenerate

  assign supply_s  = pin_q[fwp_pkg::PIN_SUP];
  assign clk_rise  = pin_q[fwp_pkg::PIN_CLK] & ~clk_prev_q;
  assign frame_end = (frame_q == fwp_pkg::FR_SEL) & pin_q[fwp_pkg::PIN_SEL];
  assign wp_locked = ~pin_q[fwp_pkg::PIN_WP] & ~quad_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_prev_q <= 1'b0;
    else
      clk_prev_q <= pin_q[fwp_pkg::PIN_CLK];
  end

  // frame tracking and bit count modulo one byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_q   <= fwp_pkg::FR_IDLE;
      bit_cnt_q <= '0;
    end
    else
    begin
      case (frame_q)
        fwp_pkg::FR_IDLE:
        begin
          bit_cnt_q <= '0;
          if (!pin_q[fwp_pkg::PIN_SEL])
            frame_q <= fwp_pkg::FR_SEL;
        end
        fwp_pkg::FR_SEL:
        begin
          if (pin_q[fwp_pkg::PIN_SEL])
            frame_q <= fwp_pkg::FR_IDLE;
          else if (clk_rise)
            bit_cnt_q <= bit_cnt_q + 1'b1;
        end
        default:
          frame_q <= fwp_pkg::FR_IDLE;
      endcase
    end
  end

  // the decoder may hand over its command at any point of the frame; it is judged when the frame ends
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_q <= 1'b0;
      cmd_q  <= '0;
    end
    else if (frame_end)
      pend_q <= 1'b0;
    else if (cmd_valid && frame_q == fwp_pkg::FR_SEL)
    begin
      pend_q <= 1'b1;
      cmd_q  <= cmd;
    end
  end

  assign decide = frame_end & pend_q;
  assign addr   = cmd_q.addr[fwp_pkg::ARR_W-1:0];
  assign sect   = cmd_q.addr[fwp_pkg::SECT_LSB +: fwp_pkg::SECT_W];

  always_comb
  begin
    ok        = 1'b0;
    modifying = 1'b1;
    mask      = fwp_pkg::PAGE_MASK;
    case (cmd_q.op)
      fwp_pkg::OP_WREN, fwp_pkg::OP_WRDI:
      begin
        ok        = 1'b1;
        modifying = 1'b0;
      end
      fwp_pkg::OP_PROG, fwp_pkg::OP_ERASE_SUB, fwp_pkg::OP_ERASE_SECT:
      begin
        // bit 23 set lies past the last array byte
        ok = ~cmd_q.addr[fwp_pkg::ADDR_W-1] & ~wlock_q[sect]
             & ~bp_covers(bp_q, tb_q, sect);
        mask = (cmd_q.op == fwp_pkg::OP_PROG)      ? fwp_pkg::PAGE_MASK :
               (cmd_q.op == fwp_pkg::OP_ERASE_SUB) ? fwp_pkg::SUB_MASK :
                                                     fwp_pkg::SECT_MASK;
      end
      fwp_pkg::OP_ERASE_BULK:
      begin
        ok   = ~|wlock_q & (bp_q == fwp_pkg::BP_RST);
        mask = fwp_pkg::ARRAY_LAST;
      end
      fwp_pkg::OP_WR_STATUS:
        ok = ~wp_locked;
      fwp_pkg::OP_SECTOR_LOCK_WRITE_CMD:
        ok = ~cmd_q.addr[fwp_pkg::ADDR_W-1] & ~ldown_q[sect];
      fwp_pkg::OP_PROG_OTP:
        ok = 1'b1;
      default:
        ok = 1'b0;
    endcase
    if (modifying)
      ok = ok & wel_q & supply_s & (bit_cnt_q == '0);
  end

  // decision outputs; a refused command drives no region and no data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      exec_q    <= 1'b0;
      refused_q <= 1'b0;
      exec_op_q <= fwp_pkg::OP_WREN;
      region_q  <= '0;
      wr_byte_q <= fwp_pkg::ERASED;
    end
    else
    begin
      exec_q    <= decide & ok;
      refused_q <= decide & ~ok;
      if (decide && ok)
      begin
        exec_op_q      <= cmd_q.op;
        region_q.first <= addr & ~mask;
        region_q.last  <= addr | mask;
        region_q.otp   <= 1'b0;
        wr_byte_q      <= fwp_pkg::ERASED;
        if (cmd_q.op == fwp_pkg::OP_PROG)
          wr_byte_q <= cur_byte & cmd_q.data;
        if (cmd_q.op == fwp_pkg::OP_PROG_OTP)
        begin
          // otp byte index only, flagged apart from the array
          region_q.first <= fwp_pkg::ARR_W'(cmd_q.addr[fwp_pkg::OTP_W-1:0]);
          region_q.last  <= fwp_pkg::ARR_W'(cmd_q.addr[fwp_pkg::OTP_W-1:0]);
          region_q.otp   <= 1'b1;
          wr_byte_q      <= cur_byte & cmd_q.data;
        end
      end
    end
  end

  // write-enable latch: set by its command, spent by any accepted modifying command
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wel_q <= 1'b0;
    else if (decide && ok)
      wel_q <= (cmd_q.op == fwp_pkg::OP_WREN);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bp_q <= fwp_pkg::BP_RST;
      tb_q <= fwp_pkg::TB_RST;
    end
    else if (decide && ok && cmd_q.op == fwp_pkg::OP_WR_STATUS)
    begin
      bp_q <= cmd_q.data[fwp_pkg::WS_BP_LSB +: 4];
      tb_q <= cmd_q.data[fwp_pkg::WS_TB];
    end
  end

  // volatile lock bits; lock-down only ever sets until reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wlock_q <= '0;
      ldown_q <= '0;
    end
    else if (decide && ok && cmd_q.op == fwp_pkg::OP_SECTOR_LOCK_WRITE_CMD)
    begin
      wlock_q[sect] <= cmd_q.data[fwp_pkg::LK_WRITE];
      ldown_q[sect] <= cmd_q.data[fwp_pkg::LK_DOWN];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      refused_cnt_q <= '0;
    else if (decide && !ok && refused_cnt_q != '1)
      refused_cnt_q <= refused_cnt_q + 1'b1;
  end

  // apb: read data is captured in the setup cycle, so no wait states are needed
  assign pready    = 1'b1;
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quad_q     <= 1'b0;
      lock_sel_q <= '0;
    end
    else if (apb_wr)
    begin
      if (paddr == fwp_pkg::REG_CONFIG)
        quad_q <= pwdata[fwp_pkg::CFG_QUAD];
      if (paddr == fwp_pkg::REG_LOCK_SEL)
        lock_sel_q <= pwdata[fwp_pkg::SECT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (apb_setup)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
      case (paddr)
        fwp_pkg::REG_STATUS:
        begin
          prdata[fwp_pkg::ST_WEL]             <= wel_q;
          prdata[fwp_pkg::ST_BP_LSB +: 4]     <= bp_q;
          prdata[fwp_pkg::ST_TB]              <= tb_q;
          prdata[fwp_pkg::ST_WPLOCK]          <= wp_locked;
          prdata[fwp_pkg::ST_SUPPLY]          <= supply_s;
        end
        fwp_pkg::REG_CONFIG:
          prdata[fwp_pkg::CFG_QUAD]           <= quad_q;
        fwp_pkg::REG_LOCK_SEL:
          prdata[fwp_pkg::SECT_W-1:0]         <= lock_sel_q;
        fwp_pkg::REG_LOCK_STAT:
        begin
          prdata[fwp_pkg::LK_WRITE]           <= wlock_q[lock_sel_q];
          prdata[fwp_pkg::LK_DOWN]            <= ldown_q[lock_sel_q];
        end
        fwp_pkg::REG_REFUSED:
          prdata[CNT_W-1:0]                   <= refused_cnt_q;
        default:
          pslverr <= 1'b1;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: sim/fwp_array_protect_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fwp_array_protect_sva #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic                 pclk,
  input wire logic                 presetn,
  // pins
  input wire logic                 ser_clk,
  input wire logic                 ser_sel_n,
  input wire logic                 supply_ok,
  // decision
  input wire logic                 exec_q,
  input wire logic                 refused_q,
  input wire fwp_pkg::fwp_op_t     exec_op_q,
  input wire fwp_pkg::fwp_region_t region_q,
  input wire logic [7:0]           wr_byte_q
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] clk_q;
  logic [2:0] sel_q;
  logic [2:0] bits_q;
  logic       wel_q;
  logic       mod;
  assign mod = !(exec_op_q inside {fwp_pkg::OP_WREN, fwp_pkg::OP_WRDI});
  // own synchronisers, so the count lags the pins as the block's does
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      clk_q <= 3'h0;
      sel_q <= 3'h7;
    end
    else
    begin
      clk_q <= {clk_q[1:0], ser_clk};
      sel_q <= {sel_q[1:0], ser_sel_n};
    end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      bits_q <= 3'h0;
    else if (sel_q[2:1] == 2'b10)
      bits_q <= 3'h0;
    else if (!sel_q[1] && clk_q[2:1] == 2'b01)
      bits_q <= bits_q + 3'h1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      wel_q <= 1'b0;
    else if (exec_q)
      wel_q <= exec_op_q == fwp_pkg::OP_WREN;
  sequence s_low_supply;
    !supply_ok [*4];
  endsequence
  sequence s_verdict;
    exec_q || refused_q;
  endsequence
  property p_span(fwp_pkg::fwp_op_t op, logic [22:0] m);
    exec_q && exec_op_q == op |-> (region_q.first & m) == 0 && region_q.last == (region_q.first | m) && !region_q.otp;
  endproperty
  chk_one_verdict: assert property (s_verdict |-> !(exec_q && refused_q) ##1 !(exec_q || refused_q))
    else $error("bad verdict pulse");
  chk_supply_gate: assert property (s_low_supply ##1 exec_q |-> !mod)
    else $error("write taken with supply low");
  chk_latch_gate: assert property (exec_q && mod |-> wel_q)
    else $error("write taken without latch");
  chk_whole_bytes: assert property (exec_q && mod |-> bits_q == 3'h0)
    else $error("write taken on partial byte");
  chk_page_span: assert property (p_span(fwp_pkg::OP_PROG, fwp_pkg::PAGE_MASK))
    else $error("bad page region");
  chk_sub_span: assert property (p_span(fwp_pkg::OP_ERASE_SUB, fwp_pkg::SUB_MASK))
    else $error("bad subsector region");
  chk_sect_span: assert property (p_span(fwp_pkg::OP_ERASE_SECT, fwp_pkg::SECT_MASK))
    else $error("bad sector region");
  chk_bulk_span: assert property (p_span(fwp_pkg::OP_ERASE_BULK, fwp_pkg::ARRAY_LAST))
    else $error("bad bulk region");
  chk_erase_ones: assert property (exec_q && exec_op_q inside {[fwp_pkg::OP_ERASE_SUB:fwp_pkg::OP_ERASE_BULK]}
    |-> wr_byte_q == fwp_pkg::ERASED)
    else $error("erase not to ones");
  chk_otp_apart: assert property (exec_q && exec_op_q == fwp_pkg::OP_PROG_OTP |-> region_q.otp && region_q.last < 64)
    else $error("bad otp region");
endmodule
bind fwp_array_protect fwp_array_protect_sva #(.CNT_W(CNT_W)) u_sva (
  .pclk(pclk), .presetn(presetn), .ser_clk(ser_clk), .ser_sel_n(ser_sel_n), .supply_ok(supply_ok),
  .exec_q(exec_q), .refused_q(refused_q), .exec_op_q(exec_op_q), .region_q(region_q), .wr_byte_q(wr_byte_q)
);
`default_nettype wire

// File: sim/fwp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fwp_host_model (
  // clock
  input  wire logic         pclk,
  // link and decoded command
  output logic              ser_clk,
  output logic              ser_sel_n,
  output logic              cmd_valid,
  output fwp_pkg::fwp_cmd_t cmd,
  output logic [7:0]        cur_byte
);
  initial
  begin
    ser_clk = 1'b0;
    ser_sel_n = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    cur_byte = 8'h00;
  end
  // serial clock stands low between frames, its edges never meet pclk's
  task automatic frame(input fwp_pkg::fwp_op_t op, input logic [23:0] a, input logic [7:0] d,
                       input logic [7:0] cb, input int n);
    @(posedge pclk);
    ser_sel_n <= 1'b0;
    cur_byte <= cb;
    repeat (3) @(posedge pclk);
    #3;
    for (int i = 0; i < n; i++)
    begin
      #62.5 ser_clk = 1'b1;
      #62.5 ser_clk = 1'b0;
    end
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd <= '{op: op, addr: a, data: d};
    @(posedge pclk);
    cmd_valid <= 1'b0;
    cmd <= fwp_pkg::fwp_cmd_t'(~cmd);
    @(posedge pclk);
    ser_sel_n <= 1'b1;
    repeat (6) @(posedge pclk);
    cur_byte <= ~cb;
  endtask
endmodule
`default_nettype wire

// File: sim/fwp_array_protect_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fwp_array_protect_bench;
  localparam fwp_pkg::fwp_op_t P = fwp_pkg::OP_PROG;
  localparam fwp_pkg::fwp_op_t LK = fwp_pkg::OP_SECTOR_LOCK_WRITE_CMD;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, wr_prot_n, supply_ok;
  logic                 ser_clk, ser_sel_n, cmd_valid, exec_q, refused_q;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata;
  logic [32:0]          rd;
  logic [7:0]           cur_byte, wr_byte_q, cb;
  logic [15:0]          lo;
  logic [22:0]          m;
  logic [60:0]          note;
  logic [60:0]          notes[$];
  fwp_pkg::fwp_cmd_t    cmd;
  fwp_pkg::fwp_op_t     exec_op_q;
  fwp_pkg::fwp_region_t region_q, rg;
  int                   n_fail, n_checks, n_ref, c;
  int                   seed = 50339;
  always #5 pclk = ~pclk;
  fwp_array_protect #(.CNT_W(16)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .ser_clk(ser_clk),
    .ser_sel_n(ser_sel_n), .wr_prot_n(wr_prot_n), .supply_ok(supply_ok), .cmd_valid(cmd_valid), .cmd(cmd),
    .cur_byte(cur_byte), .exec_q(exec_q), .refused_q(refused_q), .exec_op_q(exec_op_q), .region_q(region_q),
    .wr_byte_q(wr_byte_q));
  fwp_host_model host (.pclk(pclk), .ser_clk(ser_clk), .ser_sel_n(ser_sel_n), .cmd_valid(cmd_valid),
    .cmd(cmd), .cur_byte(cur_byte));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input fwp_pkg::fwp_op_t op, input logic [23:0] a, input logic [7:0] d, input int n,
                     input logic ok);
    cb = 8'($random(seed));
    case (op)
      fwp_pkg::OP_PROG:       m = fwp_pkg::PAGE_MASK;
      fwp_pkg::OP_ERASE_SUB:  m = fwp_pkg::SUB_MASK;
      fwp_pkg::OP_ERASE_SECT: m = fwp_pkg::SECT_MASK;
      default:                m = fwp_pkg::ARRAY_LAST;
    endcase
    rg = '{a[22:0] & ~m, a[22:0] | m, 1'b0};
    if (op == fwp_pkg::OP_PROG_OTP)
      rg = '{{17'h0, a[5:0]}, {17'h0, a[5:0]}, 1'b1};
    notes.push_back({ok, ok && op inside {[P:fwp_pkg::OP_ERASE_BULK], fwp_pkg::OP_PROG_OTP}, op, rg,
                     op inside {P, fwp_pkg::OP_PROG_OTP} ? cb & d : fwp_pkg::ERASED});
    n_ref += !ok;
    host.frame(op, a, d, cb, n);
  endtask
  task automatic wrun(input fwp_pkg::fwp_op_t op, input logic [23:0] a, input logic [7:0] d, input int n,
                      input logic ok);
    run(fwp_pkg::OP_WREN, 24'h0, 8'h0, 8, 1'b1);
    run(op, a, d, n, ok);
  endtask
  always @(posedge pclk)
    if (exec_q === 1'b1 || refused_q === 1'b1)
    begin
      note = notes.pop_front();
      chk({refused_q, exec_q}, {~note[60], note[60]});
      if (note[60])
        chk(exec_op_q, note[58:55]);
      if (note[59])
        chk({region_q, wr_byte_q}, note[54:0]);
    end
  initial
  begin
    pclk = 1'b0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    wr_prot_n = 1'b1;
    supply_ok = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(0, fwp_pkg::REG_STATUS, 0);
    chk(rd, 33'h80);
    apb(0, 12'h020, 0);
    chk(rd, 33'h100000000);
    run(P, 24'h000100, 8'h5a, 32, 1'b0);
    wrun(P, 24'h4012ab, 8'h5a, 32, 1'b1);
    run(P, 24'h4012ab, 8'h0f, 8, 1'b0);
    wrun(fwp_pkg::OP_WRDI, 0, 0, 8, 1'b1);
    run(P, 24'h000000, 0, 8, 1'b0);
    wrun(P, 24'h000000, 0, 12, 1'b0);
    run(P, 24'h800000, 0, 8, 1'b0);
    run(fwp_pkg::fwp_op_t'(4'hf), 0, 0, 8, 1'b0);
    run(fwp_pkg::OP_ERASE_SUB, 24'h123456, 0, 16, 1'b1);
    wrun(fwp_pkg::OP_ERASE_SECT, 24'h7f1234, 0, 8, 1'b1);
    wrun(fwp_pkg::OP_ERASE_BULK, 0, 0, 8, 1'b1);
    wrun(fwp_pkg::OP_PROG_OTP, 24'h000025, 8'h3c, 16, 1'b1);
    supply_ok <= 1'b0;
    wrun(P, 24'h2000ff, 0, 8, 1'b0);
    supply_ok <= 1'b1;
    run(P, 24'h2000ff, 0, 8, 1'b1);
    for (int tb = 0; tb < 2; tb++)
      for (int bp = 0; bp < 16; bp++)
      begin
        c = bp == 0 ? 0 : bp > 7 ? 128 : 1 << (bp - 1);
        wrun(fwp_pkg::OP_WR_STATUS, 0, 8'(tb * 16 + bp), 8, 1'b1);
        apb(0, fwp_pkg::REG_STATUS, 0);
        chk(rd, 33'(32'h80 | tb << 5 | bp << 1));
        lo = 16'($random(seed));
        if (c > 0)
          wrun(fwp_pkg::OP_ERASE_SECT, {1'b0, 7'(tb ? c - 1 : 128 - c), lo}, 0, 8, 1'b0);
        if (c < 128)
          wrun(fwp_pkg::OP_ERASE_SECT, {1'b0, 7'(tb ? c : 127 - c), lo}, 0, 8, 1'b1);
      end
    wrun(fwp_pkg::OP_WR_STATUS, 0, 0, 8, 1'b1);
    wrun(LK, 24'h050000, 8'h01, 8, 1'b1);
    wrun(fwp_pkg::OP_ERASE_SUB, 24'h05a000, 0, 8, 1'b0);
    wrun(fwp_pkg::OP_ERASE_BULK, 0, 0, 8, 1'b0);
    wrun(LK, 24'h050000, 8'h02, 8, 1'b1);
    wrun(LK, 24'h050000, 8'h01, 8, 1'b0);
    wrun(fwp_pkg::OP_ERASE_SUB, 24'h05a000, 0, 8, 1'b1);
    apb(1, fwp_pkg::REG_LOCK_SEL, 5);
    apb(0, fwp_pkg::REG_LOCK_STAT, 0);
    chk(rd, 33'h2);
    wr_prot_n <= 1'b0;
    wrun(fwp_pkg::OP_WR_STATUS, 0, 8'h03, 8, 1'b0);
    apb(0, fwp_pkg::REG_STATUS, 0);
    chk(rd, 33'hc1);
    apb(1, fwp_pkg::REG_CONFIG, 1);
    wrun(fwp_pkg::OP_WR_STATUS, 0, 0, 8, 1'b1);
    wr_prot_n <= 1'b1;
    apb(0, fwp_pkg::REG_REFUSED, 0);
    chk(rd, 33'(n_ref));
    chk(notes.size(), 0);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1, fwp_pkg::REG_LOCK_SEL, 5);
    apb(0, fwp_pkg::REG_LOCK_STAT, 0);
    chk(rd, 33'h0);
    finish_test();
  end
  initial
  begin
    #1_000_000;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
